// ### hdl/smd_consts.vh
`ifndef SMD_CONSTS_VH
`define SMD_CONSTS_VH

// ****************************************
// Monitor item numbers
// ****************************************
`define SMD_ITEM_SPEED_FB     4'h0
`define SMD_ITEM_SPEED_CMD    4'h1
`define SMD_ITEM_TORQUE_CMD   4'h2
`define SMD_ITEM_INDEX_OFS    4'h3
`define SMD_ITEM_ELEC_ANGLE   4'h4
`define SMD_ITEM_IN_SIG       4'h5
`define SMD_ITEM_OUT_SIG      4'h6
`define SMD_ITEM_PULSE_SPEED  4'h7
`define SMD_ITEM_POS_DEV      4'h8
`define SMD_ITEM_CUM_LOAD     4'h9
`define SMD_ITEM_REGEN_LOAD   4'ha
`define SMD_ITEM_DB_LOAD      4'hb
`define SMD_ITEM_CMD_CNT      4'hc
`define SMD_ITEM_FB_CNT       4'hd
`define SMD_ITEM_COUNT        4'he
`define SMD_ITEM_LAST         4'hd

// ****************************************
// Counter half prefix codes
// ****************************************
`define SMD_PREFIX_NONE       2'h0
`define SMD_PREFIX_HIGH       2'h1
`define SMD_PREFIX_LOW        2'h2

// ****************************************
// Signal indicator widths
// ****************************************
`define SMD_IN_SIG_WIDTH      8
`define SMD_OUT_SIG_WIDTH     7

// ****************************************
// Timing
// ****************************************
`define SMD_CLK_KHZ           25000
`define SMD_DATA_HOLD_MS      1000
`define SMD_LOAD_WINDOW_MS    10000

`endif

// ### hdl/smd_monitor.v
`timescale 1ns/1ps
`include "smd_consts.vh"

module smd_monitor #(
	parameter HOLD_CYCLES   = `SMD_DATA_HOLD_MS * `SMD_CLK_KHZ,
	parameter WINDOW_CYCLES = `SMD_LOAD_WINDOW_MS * `SMD_CLK_KHZ
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Operator keys, high while pressed
	input  wire        key_data,
	input  wire        key_up,
	input  wire        key_down,
	// Control mode
	input  wire        position_mode,
	// Quantities from the servo loops
	input  wire [15:0] speed_feedback,
	input  wire [15:0] speed_command,
	input  wire [15:0] torque_command,
	input  wire [15:0] electrical_angle,
	input  wire [15:0] command_pulse_speed,
	input  wire [31:0] position_deviation,
	input  wire [15:0] cumulative_load,
	input  wire [15:0] regen_load,
	input  wire [15:0] dbrake_load,
	// Encoder and command pulse train
	input  wire        enc_a,
	input  wire        enc_b,
	input  wire        enc_z,
	input  wire        cmd_pulse,
	input  wire        cmd_dir,
	// Input signal pin levels, high means off
	input  wire        run_command_in,
	input  wire        gain_reduction_in,
	input  wire        forward_limit_in,
	input  wire        reverse_limit_in,
	input  wire        alarm_reset_in,
	input  wire        forward_current_limit_in,
	input  wire        reverse_current_limit_in,
	input  wire        sensor_on_in,
	// Output signal pin levels, high means off
	input  wire        alarm_out,
	input  wire        positioning_done_out,
	input  wire        rotation_detected_out,
	input  wire        servo_ready_out,
	input  wire        alarm_code_bit1_out,
	input  wire        alarm_code_bit2_out,
	input  wire        alarm_code_bit3_out,
	// Display
	output reg         disp_value_view,
	output reg  [3:0]  disp_item,
	output reg  [31:0] disp_value,
	output reg  [1:0]  disp_prefix,
	output reg         disp_hex,
	output reg         disp_blank,
	output reg  [7:0]  disp_seg_upper,
	output reg  [7:0]  disp_seg_lower
);
	localparam ST_NUMBER = 1'b0;
	localparam ST_VALUE  = 1'b1;
	// ****************************************
	// Reset release
	// ****************************************
	reg        rst_meta_n;
	reg        rst_sync_n;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end
	// ****************************************
	// Key handling
	// ****************************************
	reg        up_q;
	reg        down_q;
	reg [31:0] hold_cnt;
	reg        hold_done;
	reg        state;
	reg [3:0]  item;
	reg        low_half;
	wire       up_rise   = key_up & ~up_q;
	wire       down_rise = key_down & ~down_q;
	wire       any_rise  = up_rise | down_rise;
	wire       both_held = key_up & key_down;
	wire       is_counter = (item == `SMD_ITEM_CMD_CNT) || (item == `SMD_ITEM_FB_CNT);
	wire       hold_fire = key_data & ~hold_done & (hold_cnt == HOLD_CYCLES - 1);
	wire       clr_req   = (state == ST_VALUE) & is_counter & any_rise & both_held;
	wire       clr_cmd   = clr_req & (item == `SMD_ITEM_CMD_CNT);
	wire       clr_fb    = clr_req & (item == `SMD_ITEM_FB_CNT);
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			up_q      <= 1'b0;
			down_q    <= 1'b0;
			hold_cnt  <= 32'h0000_0000;
			hold_done <= 1'b0;
			state     <= ST_NUMBER;
			item      <= `SMD_ITEM_SPEED_FB;
			low_half  <= 1'b0;
		end else begin
			up_q   <= key_up;
			down_q <= key_down;
			if (!key_data) begin
				hold_cnt  <= 32'h0000_0000;
				hold_done <= 1'b0;
			end else if (hold_fire) begin
				hold_done <= 1'b1;
			end else if (!hold_done) begin
				hold_cnt <= hold_cnt + 32'h0000_0001;
			end
			case (state)
				ST_NUMBER: begin
					if (hold_fire) begin
						state <= ST_VALUE;
						low_half <= 1'b0;
					end else if (any_rise && !both_held) begin
						if (up_rise)
							item <= (item == `SMD_ITEM_LAST) ? 4'h0 : item + 4'h1;
						else
							item <= (item == 4'h0) ? `SMD_ITEM_LAST : item - 4'h1;
					end
				end
				ST_VALUE: begin
					if (hold_fire)
						state <= ST_NUMBER;
					else if (is_counter && any_rise && !both_held)
						low_half <= ~low_half;
				end
				default: state <= ST_NUMBER;
			endcase
		end
	end
	// ****************************************
	// Pulse counters
	// ****************************************
	reg        a_q;
	reg        b_q;
	reg        z_q;
	reg        pulse_q;
	reg [31:0] fb_cnt;
	reg [31:0] cmd_cnt;
	reg [31:0] index_ofs;
	reg [31:0] fb_step;
	reg [31:0] cmd_step;
	wire [1:0] quad_prev = {a_q, b_q};
	wire [1:0] quad_now  = {enc_a, enc_b};
	always @* begin
		case ({quad_prev, quad_now})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: fb_step = 32'h0000_0001;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: fb_step = 32'hffff_ffff;
			default: fb_step = 32'h0000_0000;
		endcase
	end
	// Command pulses only in position control
	always @* begin
		cmd_step = 32'h0000_0000;
		if (position_mode && cmd_pulse && !pulse_q)
			cmd_step = cmd_dir ? 32'hffff_ffff : 32'h0000_0001;
	end
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			a_q       <= 1'b0;
			b_q       <= 1'b0;
			z_q       <= 1'b0;
			pulse_q   <= 1'b0;
			fb_cnt    <= 32'h0000_0000;
			cmd_cnt   <= 32'h0000_0000;
			index_ofs <= 32'h0000_0000;
		end else begin
			a_q     <= enc_a;
			b_q     <= enc_b;
			z_q     <= enc_z;
			pulse_q <= cmd_pulse;
			// Clear, a pulse in the same cycle still counts
			fb_cnt  <= (clr_fb ? 32'h0000_0000 : fb_cnt) + fb_step;
			cmd_cnt <= (clr_cmd ? 32'h0000_0000 : cmd_cnt) + cmd_step;
			// Restart on phase Z rising edge
			if (enc_z && !z_q)
				index_ofs <= 32'h0000_0000;
			else
				index_ofs <= index_ofs + fb_step;
		end
	end
	// ****************************************
	// Load ratio windows
	// ****************************************
	reg [31:0] win_cnt;
	reg [15:0] cum_hold;
	reg [15:0] regen_hold;
	reg [15:0] dbrake_hold;
	// Display refreshes only at window end so the figure stays readable
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			win_cnt     <= 32'h0000_0000;
			cum_hold    <= 16'h0000;
			regen_hold  <= 16'h0000;
			dbrake_hold <= 16'h0000;
		end else if (win_cnt == WINDOW_CYCLES - 1) begin
			win_cnt <= 32'h0000_0000;
			cum_hold <= cumulative_load;
			regen_hold <= regen_load;
			dbrake_hold <= dbrake_load;
		end else begin
			win_cnt <= win_cnt + 32'h0000_0001;
		end
	end
	// ****************************************
	// Signal indicators
	// ****************************************
	wire [`SMD_IN_SIG_WIDTH-1:0]  in_sig;
	wire [`SMD_OUT_SIG_WIDTH-1:0] out_sig;
	assign in_sig = {sensor_on_in, reverse_current_limit_in, forward_current_limit_in,
		alarm_reset_in, reverse_limit_in, forward_limit_in, gain_reduction_in,
		run_command_in};
	assign out_sig = {alarm_code_bit3_out, alarm_code_bit2_out, alarm_code_bit1_out,
		servo_ready_out, rotation_detected_out, positioning_done_out, alarm_out};
	// ****************************************
	// Display selection
	// ****************************************
	reg [31:0] next_value;
	reg [1:0]  next_prefix;
	reg        next_hex;
	reg        next_blank;
	reg [7:0]  next_upper;
	reg [7:0]  next_lower;
	reg [31:0] cnt_sel;
	always @* begin
		next_value  = 32'h0000_0000;
		next_prefix = `SMD_PREFIX_NONE;
		next_hex    = 1'b0;
		next_blank  = 1'b0;
		next_upper  = 8'h00;
		next_lower  = 8'h00;
		cnt_sel     = (item == `SMD_ITEM_CMD_CNT) ? cmd_cnt : fb_cnt;
		case (item)
			`SMD_ITEM_SPEED_FB:    next_value = {{16{speed_feedback[15]}}, speed_feedback};
			`SMD_ITEM_SPEED_CMD:   next_value = {{16{speed_command[15]}}, speed_command};
			`SMD_ITEM_TORQUE_CMD:  next_value = {{16{torque_command[15]}}, torque_command};
			`SMD_ITEM_INDEX_OFS:   next_value = index_ofs;
			`SMD_ITEM_ELEC_ANGLE:  next_value = {16'h0000, electrical_angle};
			`SMD_ITEM_IN_SIG: begin
				// Upper when high, lower when low
				next_upper = in_sig;
				next_lower = ~in_sig;
			end
			`SMD_ITEM_OUT_SIG: begin
				// Upper when high, lower when low
				next_upper = {1'b0, out_sig};
				next_lower = {1'b0, ~out_sig};
			end
			`SMD_ITEM_PULSE_SPEED: begin
				next_value = {{16{command_pulse_speed[15]}}, command_pulse_speed};
				next_blank = ~position_mode;
			end
			`SMD_ITEM_POS_DEV: begin
				next_value = position_deviation;
				next_blank = ~position_mode;
			end
			`SMD_ITEM_CUM_LOAD:    next_value = {16'h0000, cum_hold};
			`SMD_ITEM_REGEN_LOAD:  next_value = {16'h0000, regen_hold};
			`SMD_ITEM_DB_LOAD:     next_value = {16'h0000, dbrake_hold};
			`SMD_ITEM_CMD_CNT, `SMD_ITEM_FB_CNT: begin
				// One 16-bit half of the 32-bit count
				next_hex = 1'b1;
				if (low_half) begin
					next_value  = {16'h0000, cnt_sel[15:0]};
					next_prefix = `SMD_PREFIX_LOW;
				end else begin
					next_value  = {16'h0000, cnt_sel[31:16]};
					next_prefix = `SMD_PREFIX_HIGH;
				end
			end
			default:               next_blank = 1'b1;
		endcase
	end
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			disp_value_view <= 1'b0;
			disp_item       <= `SMD_ITEM_SPEED_FB;
			disp_value      <= 32'h0000_0000;
			disp_prefix     <= `SMD_PREFIX_NONE;
			disp_hex        <= 1'b0;
			disp_blank      <= 1'b0;
			disp_seg_upper  <= 8'h00;
			disp_seg_lower  <= 8'h00;
		end else begin
			disp_value_view <= state;
			disp_item       <= item;
			disp_value      <= next_value;
			disp_prefix     <= next_prefix;
			disp_hex        <= next_hex;
			disp_blank      <= next_blank;
			disp_seg_upper  <= next_upper;
			disp_seg_lower  <= next_lower;
		end
	end
endmodule // smd_monitor

// ### dv/smd_checker.sv
`timescale 1ns/1ps
`include "smd_consts.vh"
module smd_checker #(
	parameter HOLD_CYCLES = 8
) (
	// Clock, reset, keys
	input logic        mclk,
	input logic        rst_n,
	input logic        key_data,
	input logic        key_up,
	input logic        key_down,
	// Pulses and mode
	input logic        position_mode,
	input logic        enc_a,
	input logic        enc_b,
	input logic        cmd_pulse,
	// Display
	input logic        disp_value_view,
	input logic [3:0]  disp_item,
	input logic [31:0] disp_value,
	input logic [1:0]  disp_prefix,
	input logic        disp_hex,
	input logic        disp_blank,
	input logic [7:0]  disp_seg_upper,
	input logic [7:0]  disp_seg_lower
);
	// ****************
	// Hold counter
	// ****************
	logic [31:0] hold_cnt;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			hold_cnt <= 32'h0;
		else
			hold_cnt <= key_data ? hold_cnt + 32'h1 : 32'h0;
	end
	wire fire     = key_data && (hold_cnt == HOLD_CYCLES - 1);
	wire ctr_view = disp_value_view && (disp_item >= `SMD_ITEM_CMD_CNT);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_quiet;
		$stable({enc_a, enc_b, cmd_pulse});
	endsequence
	sequence s_swap;
		ctr_view && disp_prefix == `SMD_PREFIX_HIGH && key_up && !key_down && !$past(key_up);
	endsequence
	sequence s_clear;
		ctr_view && key_up && key_down && ($rose(key_up) || $rose(key_down))
			&& $stable({enc_a, enc_b, cmd_pulse});
	endsequence
	property p_item_range;
		disp_item <= `SMD_ITEM_LAST;
	endproperty
	a_item_range: assert property (p_item_range) else $error("item out of range");
	property p_in_seg;
		disp_item == `SMD_ITEM_IN_SIG |-> disp_seg_lower == ~disp_seg_upper;
	endproperty
	a_in_seg: assert property (p_in_seg) else $error("input segments not paired");
	property p_out_seg;
		disp_item == `SMD_ITEM_OUT_SIG |-> !disp_seg_upper[7] && !disp_seg_lower[7]
			&& disp_seg_lower[6:0] == ~disp_seg_upper[6:0];
	endproperty
	a_out_seg: assert property (p_out_seg) else $error("output segments wrong");
	property p_hex;
		disp_item >= `SMD_ITEM_CMD_CNT |-> disp_hex;
	endproperty
	a_hex: assert property (p_hex) else $error("counter not hex");
	property p_blank;
		(disp_item == `SMD_ITEM_PULSE_SPEED || disp_item == `SMD_ITEM_POS_DEV)
			&& !$past(position_mode) |-> disp_blank;
	endproperty
	a_blank: assert property (p_blank) else $error("position item not blanked");
	property p_enter_high;
		$rose(disp_value_view) && disp_item >= `SMD_ITEM_CMD_CNT |-> disp_prefix == `SMD_PREFIX_HIGH;
	endproperty
	a_enter_high: assert property (p_enter_high) else $error("entry not upper half");
	property p_swap;
		s_swap |-> ##2 disp_prefix == `SMD_PREFIX_LOW;
	endproperty
	a_swap: assert property (p_swap) else $error("half not swapped");
	property p_clear;
		s_clear ##1 s_quiet [*2] |-> disp_value == 32'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared");
	property p_hold;
		fire |=> ##1 disp_value_view != $past(disp_value_view);
	endproperty
	a_hold: assert property (p_hold) else $error("view not toggled");
	property p_no_hold;
		!fire |=> ##1 $stable(disp_value_view);
	endproperty
	a_no_hold: assert property (p_no_hold) else $error("view toggled early");
endmodule // smd_checker

// ### dv/smd_operator.sv
`timescale 1ns/1ps
module smd_operator #(
	parameter HOLD_CYCLES = 8
) (
	// Clock
	input  logic mclk,
	// Keys, high while pressed
	output logic key_data,
	output logic key_up,
	output logic key_down
);
	initial begin
		key_data = 1'b0;
		key_up   = 1'b0;
		key_down = 1'b0;
	end
	task press(input logic u, input logic d);
		@(negedge mclk);
		key_up   = u;
		key_down = d;
		@(negedge mclk);
		key_up   = 1'b0;
		key_down = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task hold_data;
		@(negedge mclk);
		key_data = 1'b1;
		repeat (HOLD_CYCLES) @(negedge mclk);
		key_data = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
endmodule // smd_operator

// ### dv/tb.sv
`timescale 1ns/1ps
`include "smd_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	localparam HOLD = 8;
	int num_errors = 0;
	int tests_run = 0;
	int ph = 0;
	logic mclk, rst_n, position_mode, enc_a, enc_b, enc_z, cmd_pulse, cmd_dir;
	wire key_data, key_up, key_down;
	logic [15:0] speed_feedback = 16'h8001, speed_command = 16'h0123, torque_command = 16'h0064;
	logic [15:0] electrical_angle = 16'h00b4, command_pulse_speed = 16'hfff6;
	logic [31:0] position_deviation = 32'h12345678;
	logic [15:0] cumulative_load = 16'h0050, regen_load = 16'h0021, dbrake_load = 16'h0007;
	logic [7:0] ip = 8'h96;
	logic [6:0] op = 7'h35;
	wire run_command_in = ip[0], gain_reduction_in = ip[1], forward_limit_in = ip[2];
	wire reverse_limit_in = ip[3], alarm_reset_in = ip[4], forward_current_limit_in = ip[5];
	wire reverse_current_limit_in = ip[6], sensor_on_in = ip[7];
	wire alarm_out = op[0], positioning_done_out = op[1], rotation_detected_out = op[2];
	wire servo_ready_out = op[3], alarm_code_bit1_out = op[4], alarm_code_bit2_out = op[5];
	wire alarm_code_bit3_out = op[6];
	wire disp_value_view, disp_hex, disp_blank;
	wire [3:0] disp_item;
	wire [31:0] disp_value;
	wire [1:0] disp_prefix;
	wire [7:0] disp_seg_upper, disp_seg_lower;
	logic [31:0] exp_val [0:11] = '{32'hffff8001, 32'h123, 32'h64, 32'h0, 32'hb4, 32'h0,
		32'h0, 32'hfffffff6, 32'h12345678, 32'h50, 32'h21, 32'h7};
	smd_monitor #(.HOLD_CYCLES(HOLD), .WINDOW_CYCLES(16)) i_smd_monitor (.*);
	smd_operator #(.HOLD_CYCLES(HOLD)) i_smd_operator (.*);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One quadrature step, then time for count and display
	task enc_step(input int d);
		ph = (ph + d) & 3;
		@(negedge mclk);
		enc_a = ph[1];
		enc_b = ph[1] ^ ph[0];
		repeat (3) @(negedge mclk);
	endtask
	task t_items;
		int i;
		i_smd_operator.press(0, 1);
		`CHK(disp_item, 4'hd)
		i_smd_operator.press(1, 0);
		`CHK(disp_item, 4'h0)
		for (i = 0; i < 12; i++) begin
			if (i == 5) begin
				`CHK(disp_seg_upper, 8'h96)
				`CHK(disp_seg_lower, 8'h69)
			end else if (i == 6) begin
				`CHK(disp_seg_upper, 8'h35)
				`CHK(disp_seg_lower, 8'h4a)
			end else begin
				i_smd_operator.hold_data();
				`CHK(disp_value, exp_val[i])
				if (i == 7) `CHK(disp_blank, 1'b1)
				i_smd_operator.hold_data();
			end
			i_smd_operator.press(1, 0);
		end
		`CHK(disp_item, 4'hc)
	endtask
	task t_fb_counter;
		i_smd_operator.press(1, 0);
		repeat (6) enc_step(1);
		i_smd_operator.hold_data();
		`CHK(disp_prefix, `SMD_PREFIX_HIGH)
		`CHK(disp_value[15:0], 16'h0)
		`CHK(disp_hex, 1'b1)
		i_smd_operator.press(1, 0);
		`CHK(disp_prefix, `SMD_PREFIX_LOW)
		`CHK(disp_value[15:0], 16'h6)
		i_smd_operator.press(1, 1);
		`CHK(disp_value[15:0], 16'h0)
		enc_step(-1);
		`CHK(disp_value[15:0], 16'hffff)
		i_smd_operator.press(0, 1);
		`CHK(disp_prefix, `SMD_PREFIX_HIGH)
		`CHK(disp_value[15:0], 16'hffff)
		i_smd_operator.hold_data();
		`CHK(disp_value_view, 1'b0)
	endtask
	task t_cmd_counter;
		i_smd_operator.press(0, 1);
		position_mode = 1'b1;
		repeat (3) begin
			@(negedge mclk) cmd_pulse = 1'b1;
			@(negedge mclk) cmd_pulse = 1'b0;
		end
		i_smd_operator.hold_data();
		i_smd_operator.press(1, 0);
		`CHK(disp_value[15:0], 16'h3)
	endtask
	initial begin
		rst_n = 1'b0;
		position_mode = 1'b0;
		{enc_a, enc_b, enc_z, cmd_pulse, cmd_dir} = 5'h0;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (3) @(negedge mclk);
		t_items;
		t_fb_counter;
		t_cmd_counter;
		end_sim;
	end
	// Hang guard, well beyond the run length
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		end_sim;
	end
endmodule // tb
bind smd_monitor smd_checker #(.HOLD_CYCLES(HOLD_CYCLES)) i_smd_checker (.*);
